// *** core/gism_pkg.sv ***
package gism_pkg;
   // -----------------------------------------------------------------
   // Buffer layout
   // -----------------------------------------------------------------
   localparam int        BUF_BYTES      = 6;
   localparam int        BUF_W          = 48;
   localparam logic [7:0] BUF_RESET     = 8'hFF;
   localparam int        CTRL_HI        = 7;
   localparam int        CTRL_LO        = 4;
   // -----------------------------------------------------------------
   // Transfer timing in primary serial clocks
   // -----------------------------------------------------------------
   localparam logic [4:0] TICK_LAST     = 5'h17;
   localparam logic [4:0] BIT_FIRST     = 5'h03;
   localparam logic [1:0] BYTE_LAST     = 2'h2;
   localparam logic [3:0] I2C_BITS      = 4'h9;
   localparam logic [3:0] SPI_BITS      = 4'h8;
   localparam logic [4:0] SPI_POST_TICK = 5'h13;
   localparam logic [4:0] I2C_POST_TICK = 5'h15;
   // -----------------------------------------------------------------
   // Control codes
   // -----------------------------------------------------------------
   localparam logic [3:0] I2C_START     = 4'h6;
   localparam logic [3:0] I2C_STOP      = 4'h1;
   localparam logic [3:0] I2C_BLANK     = 4'h0;
   localparam logic [3:0] I2C_NOTX      = 4'h7;
   localparam logic [3:0] I2C_MACK      = 4'h0;
   localparam logic [3:0] I2C_NACK_STOP = 4'h9;
   localparam logic [3:0] SPI_SEL_LOW   = 4'h8;
   localparam logic [3:0] SPI_SEL_PULSE = 4'hA;
   localparam logic [3:0] SPI_SEL_HIGH  = 4'h9;
   localparam logic [3:0] SPI_NOTX      = 4'hF;
   localparam logic [3:0] SPI_POST_HIGH = 4'h9;
   localparam logic [3:0] SPI_RB_PRE    = 4'h7;
   localparam logic [3:0] SPI_RB_POST   = 4'hF;
endpackage

// *** core/gism_edge_sync.sv ***
`timescale 1ns/100ps
module gism_edge_sync (
   input  wire logic core_clk,
   input  wire logic rst_n,
   input  wire logic asyncIn,
   output logic      level,
   output logic      rise
);
   logic stage1;
   logic stage2;

   // -----------------------------------------------------------------
   // Two-stage synchroniser followed by an edge detector.
   // -----------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         stage1 <= 1'b1;
         stage2 <= 1'b1;
         level  <= 1'b1;
         rise   <= 1'b0;
      end else begin
         stage1 <= asyncIn;
         stage2 <= stage1;
         level  <= stage2;
         rise   <= stage2 & ~level;
      end
   end
endmodule

// *** core/gism_master.sv ***
`timescale 1ns/100ps
module gism_master (
   input  wire logic                     core_clk,
   input  wire logic                     rst_n,
   input  wire logic                     bufWrite,
   input  wire logic [gism_pkg::BUF_W-1:0] bufWrData,
   input  wire logic                     startTransferCmd,
   input  wire logic                     hostSck,
   input  wire logic                     selectPinN,
   input  wire logic                     gpio3In,
   output logic      [gism_pkg::BUF_W-1:0] bufRdData,
   output logic                          busy,
   output logic                          gpio2Out,
   output logic                          gpio2OeN,
   output logic                          gpio3Out,
   output logic                          gpio3OeN,
   output logic                          gpio4Out,
   output logic                          gpio4OeN
);
   import gism_pkg::*;

   logic [7:0] masterTransferBuffer [BUF_BYTES];
   logic [4:0] tickCnt;
   logic [1:0] byteIdx;
   logic       active;
   logic       skip;
   logic       sdaRel;
   logic       sclRel;
   logic       selRel;
   logic       driveLevel;
   logic [7:0] rx;
   logic       ackBit;
   logic       next_sdaRel;
   logic       next_sclRel;
   logic       next_selRel;
   logic       next_skip;
   logic [7:0] next_rx;
   logic       next_ackBit;

   logic       sckRise;
   logic       selLevel;
   logic       sdaLevel;

   // -----------------------------------------------------------------
   // Helpers
   // -----------------------------------------------------------------
   function automatic logic [3:0] bitOf(input logic [4:0] t);
      logic [4:0] d;
      d = t - BIT_FIRST;
      return d[4:1];
   endfunction

   function automatic logic inBits(input logic [4:0] t, input logic [3:0] n);
      return (t >= BIT_FIRST) && (bitOf(t) < n);
   endfunction

   // -----------------------------------------------------------------
   // Link sampling
   // -----------------------------------------------------------------
   gism_edge_sync sckSync (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .asyncIn  (hostSck),
      .level    (),
      .rise     (sckRise)
   );

   gism_edge_sync selSync (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .asyncIn  (selectPinN),
      .level    (selLevel),
      .rise     ()
   );

   gism_edge_sync sdaSync (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .asyncIn  (gpio3In),
      .level    (sdaLevel),
      .rise     ()
   );

   // -----------------------------------------------------------------
   // Field decode of the current data word
   // -----------------------------------------------------------------
   wire [2:0] evenIdx       = {byteIdx, 1'b0};
   wire [2:0] oddIdx        = {byteIdx, 1'b1};
   wire [3:0] preByteControl  = masterTransferBuffer[evenIdx][CTRL_HI:CTRL_LO];
   wire [3:0] postByteControl = masterTransferBuffer[oddIdx][3:0];
   wire [7:0] payloadByte   = {masterTransferBuffer[evenIdx][3:0],
                               masterTransferBuffer[oddIdx][CTRL_HI:CTRL_LO]};
   wire       isSpi         = preByteControl[3];
   wire       tick          = active & sckRise & ~selLevel;
   wire       lastTick      = tickCnt == TICK_LAST;
   // Odd ticks pull the clock low and present data, even ticks release it and sample.
   wire       lowPhase      = tickCnt[0];
   wire [3:0] bitIdx        = bitOf(tickCnt);
   wire [2:0] msbIdx        = 3'(4'h7 - bitIdx);
   wire       txBit         = (bitIdx < SPI_BITS) ? payloadByte[msbIdx]
                              : (postByteControl != I2C_MACK);
   wire       i2cStopPost   = postByteControl == I2C_NACK_STOP;
   wire [3:0] i2cPreRb      = (preByteControl == I2C_BLANK && sdaRel) ? I2C_NOTX
                              : preByteControl;
   wire [3:0] i2cPostRb     = (postByteControl == I2C_MACK) ? I2C_MACK
                              : i2cStopPost ? {ackBit, 3'h1} : {ackBit, 3'h7};
   wire [3:0] preRb         = isSpi ? SPI_RB_PRE : i2cPreRb;
   wire [3:0] postRb        = isSpi ? SPI_RB_POST : i2cPostRb;

   // -----------------------------------------------------------------
   // Line sequencing per primary serial clock
   // -----------------------------------------------------------------
   always_comb begin
      next_sdaRel = sdaRel;
      next_sclRel = sclRel;
      next_selRel = selRel;
      next_skip   = skip;
      next_rx     = rx;
      next_ackBit = ackBit;
      if (tick && lastTick) begin
         next_skip = 1'b0;
         if (!skip && !isSpi && i2cStopPost) begin
            next_sdaRel = 1'b1;
         end
      end else if (tick && !skip && !isSpi) begin
         if (tickCnt == 5'h00) begin
            next_rx = BUF_RESET;
            if (preByteControl == I2C_START) begin
               next_sdaRel = 1'b1;
               next_sclRel = 1'b1;
            end else if (preByteControl == I2C_STOP) begin
               next_sclRel = 1'b0;
            end else if (preByteControl == I2C_NOTX) begin
               next_sdaRel = 1'b1;
               next_sclRel = 1'b1;
               next_skip   = 1'b1;
            end
         end else if (tickCnt == 5'h01) begin
            if (preByteControl == I2C_START || preByteControl == I2C_STOP) begin
               next_sdaRel = 1'b0;
            end
         end else if (tickCnt == 5'h02) begin
            if (preByteControl == I2C_START) begin
               next_sclRel = 1'b0;
            end else if (preByteControl == I2C_STOP) begin
               next_sclRel = 1'b1;
            end
         end else if (tickCnt == BIT_FIRST && preByteControl == I2C_STOP) begin
            next_sdaRel = 1'b1;
            next_skip   = 1'b1;
         end else if (inBits(tickCnt, I2C_BITS)) begin
            if (lowPhase) begin
               next_sclRel = 1'b0;
               next_sdaRel = txBit;
            end else begin
               next_sclRel = 1'b1;
               if (bitIdx < SPI_BITS) begin
                  next_rx = {rx[6:0], sdaLevel};
               end else begin
                  next_ackBit = sdaLevel;
               end
            end
         end else if (tickCnt == I2C_POST_TICK) begin
            next_sclRel = 1'b0;
            next_sdaRel = 1'b0;
         end else if (tickCnt == I2C_POST_TICK + 5'h01 && i2cStopPost) begin
            next_sclRel = 1'b1;
         end
      end else if (tick && !skip) begin
         if (tickCnt == 5'h00) begin
            next_rx     = BUF_RESET;
            next_sclRel = 1'b1;
            if (preByteControl == SPI_SEL_LOW) begin
               next_selRel = 1'b0;
            end else if (preByteControl == SPI_SEL_PULSE) begin
               next_selRel = 1'b1;
            end else begin
               next_selRel = 1'b1;
               next_sdaRel = 1'b1;
               next_skip   = 1'b1;
            end
         end else if (tickCnt == 5'h01 && preByteControl == SPI_SEL_PULSE) begin
            next_selRel = 1'b0;
         end else if (inBits(tickCnt, SPI_BITS)) begin
            if (lowPhase) begin
               next_sclRel = 1'b0;
               next_sdaRel = txBit;
            end else begin
               next_sclRel = 1'b1;
               next_rx     = {rx[6:0], sdaLevel};
            end
         end else if (tickCnt == SPI_POST_TICK) begin
            next_sdaRel = 1'b1;
            if (postByteControl == SPI_POST_HIGH) begin
               next_selRel = 1'b1;
            end else begin
               next_selRel = 1'b0;
            end
         end
      end
   end

   // -----------------------------------------------------------------
   // Transfer progress
   // -----------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         active  <= 1'b0;
         tickCnt <= 5'h00;
         byteIdx <= 2'h0;
      end else if (startTransferCmd) begin
         active  <= 1'b1;
         tickCnt <= 5'h00;
         byteIdx <= 2'h0;
      end else if (active && selLevel) begin
         active  <= 1'b0;
      end else if (tick) begin
         tickCnt <= lastTick ? 5'h00 : tickCnt + 5'h01;
         byteIdx <= (lastTick && byteIdx != BYTE_LAST) ? byteIdx + 2'h1 : byteIdx;
         active  <= !(lastTick && byteIdx == BYTE_LAST);
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         sdaRel     <= 1'b1;
         sclRel     <= 1'b1;
         selRel     <= 1'b1;
         skip       <= 1'b0;
         rx         <= BUF_RESET;
         ackBit     <= 1'b1;
         driveLevel <= 1'b0;
      end else begin
         sdaRel     <= next_sdaRel;
         sclRel     <= next_sclRel;
         selRel     <= next_selRel;
         skip       <= next_skip;
         rx         <= next_rx;
         ackBit     <= next_ackBit;
         driveLevel <= 1'b0;
      end
   end

   // -----------------------------------------------------------------
   // Buffer storage: host writes while idle, the master writes back.
   // -----------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         for (int i = 0; i < BUF_BYTES; i++) begin
            masterTransferBuffer[i] <= BUF_RESET;
         end
      end else if (bufWrite && !active) begin
         for (int i = 0; i < BUF_BYTES; i++) begin
            masterTransferBuffer[i] <= bufWrData[BUF_W-1-8*i -: 8];
         end
      end else if (tick && lastTick) begin
         masterTransferBuffer[evenIdx] <= {preRb, rx[7:4]};
         masterTransferBuffer[oddIdx]  <= {rx[3:0], postRb};
      end
   end

   // -----------------------------------------------------------------
   // Pins: open drain, low enable pulls the line low.
   // -----------------------------------------------------------------
   always_comb begin
      for (int i = 0; i < BUF_BYTES; i++) begin
         bufRdData[BUF_W-1-8*i -: 8] = masterTransferBuffer[i];
      end
   end

   assign busy     = active;
   assign gpio2Out = driveLevel;
   assign gpio3Out = driveLevel;
   assign gpio4Out = driveLevel;
   assign gpio2OeN = selRel;
   assign gpio3OeN = sdaRel;
   assign gpio4OeN = sclRel;
endmodule

// *** testbench/gism_chk.sv ***
`timescale 1ns/100ps
module gism_chk (
   input wire logic                       core_clk,
   input wire logic                       rst_n,
   input wire logic                       bufWrite,
   input wire logic [gism_pkg::BUF_W-1:0] bufWrData,
   input wire logic                       startTransferCmd,
   input wire logic                       hostSck,
   input wire logic                       selectPinN,
   input wire logic                       gpio3In,
   input wire logic [gism_pkg::BUF_W-1:0] bufRdData,
   input wire logic                       busy,
   input wire logic                       gpio2Out,
   input wire logic                       gpio2OeN,
   input wire logic                       gpio3Out,
   input wire logic                       gpio3OeN,
   input wire logic                       gpio4Out,
   input wire logic                       gpio4OeN
);
   import gism_pkg::*;
   wire logic [2:0] pinsOeN;
   assign pinsOeN = {gpio2OeN, gpio3OeN, gpio4OeN};
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   a_open_drain_low: assert property (!(gpio2Out || gpio3Out || gpio4Out))
      else $error("pin data not zero");
   a_reset_release: assert property (disable iff (1'b0) !rst_n |=> pinsOeN == 3'h7 && !busy)
      else $error("pins not released by reset");
   a_reset_buffer: assert property (disable iff (1'b0) !rst_n |=> bufRdData == {BUF_BYTES{BUF_RESET}})
      else $error("buffer reset value wrong");
   a_write_loads: assert property (bufWrite && !busy |=> bufRdData == $past(bufWrData))
      else $error("buffer write lost");
   a_buffer_holds: assert property (!busy && !bufWrite |=> $stable(bufRdData))
      else $error("buffer changed while idle");
   a_start_busy: assert property (startTransferCmd |=> busy)
      else $error("start did not raise busy");
   a_busy_cause: assert property ($rose(busy) |-> $past(startTransferCmd))
      else $error("busy rose without start");
   a_idle_pins: assert property (!busy && !startTransferCmd |=> $stable(pinsOeN))
      else $error("pins moved while idle");
   a_pin_tick: assert property ($changed(pinsOeN) && $past(rst_n) |->
      $past(busy) && ($past(hostSck, 2) || $past(hostSck, 3) || $past(hostSck, 4)))
      else $error("pin moved without serial clock");
   c_select_low: cover property ($fell(gpio2OeN));
   c_clock_pulled: cover property ($fell(gpio4OeN));
   c_write_refused: cover property (busy && bufWrite);
   c_transfer_done: cover property ($fell(busy));
endmodule

// *** testbench/gism_slave.sv ***
`timescale 1ns/100ps
module gism_slave (
   input wire logic       clkLine,
   input wire logic       dataLine,
   input wire logic       selLine,
   input wire logic       spiMode,
   input wire logic [7:0] txByte,
   output logic           dataOeN
);
   int bitCnt = 9;
   initial dataOeN = 1'b1;
   // A start condition needs the clock still high once the data edge has settled.
   always @(negedge dataLine) begin
      #1;
      if (!spiMode && clkLine) begin
         bitCnt = 0;
      end
   end
   always @(negedge selLine) if (spiMode) bitCnt = 0;
   always @(posedge selLine) if (spiMode) begin
      bitCnt = 9;
      dataOeN = 1'b1;
   end
   always @(posedge clkLine) if (bitCnt < 9) bitCnt = bitCnt + 1;
   // Data moves on a falling clock, most significant bit first; in SPI mode a rising select also releases it.
   always @(negedge clkLine) dataOeN = (bitCnt < 8) ? txByte[7 - bitCnt] : 1'b1;
endmodule

// *** testbench/testbench.sv ***
`timescale 1ns/100ps
module testbench;
   import gism_pkg::*;
   logic             core_clk = 1'b0;
   logic             rst_n = 1'b0;
   logic             bufWrite = 1'b0;
   logic [BUF_W-1:0] bufWrData = 48'h0;
   logic             startTransferCmd = 1'b0;
   logic             hostSck = 1'b0;
   logic             selectPinN = 1'b1;
   logic             slaveSpi = 1'b1;
   logic       [7:0] slaveByte = 8'hFF;
   logic [BUF_W-1:0] bufRdData;
   logic             busy, gpio2Out, gpio2OeN, gpio3Out, gpio3OeN, gpio4Out, gpio4OeN, slaveOeN;
   wire logic        pin2, pin3, pin4;
   int               numErrors = 0;
   int               nTests = 0;
   int               seed = 82266;
   logic       [7:0] d [3];
   // Pull-ups hold released lines high; the pin output bits stay at zero.
   assign pin2 = gpio2OeN;
   assign pin3 = gpio3OeN & slaveOeN;
   assign pin4 = gpio4OeN;
   always #4 core_clk = ~core_clk;
   gism_master dut (.core_clk(core_clk), .rst_n(rst_n), .bufWrite(bufWrite),
      .bufWrData(bufWrData), .startTransferCmd(startTransferCmd), .hostSck(hostSck),
      .selectPinN(selectPinN), .gpio3In(pin3), .bufRdData(bufRdData), .busy(busy),
      .gpio2Out(gpio2Out), .gpio2OeN(gpio2OeN), .gpio3Out(gpio3Out), .gpio3OeN(gpio3OeN),
      .gpio4Out(gpio4Out), .gpio4OeN(gpio4OeN));
   gism_slave peer (.clkLine(pin4), .dataLine(pin3), .selLine(pin2), .spiMode(slaveSpi),
      .txByte(slaveByte), .dataOeN(slaveOeN));
   task automatic check(input logic [47:0] seen, input logic [47:0] exp);
      nTests++;
      if (seen !== exp) begin
         numErrors++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic finalReport();
      $display("compares %0d mismatches %0d", nTests, numErrors);
      if (numErrors == 0 && nTests > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // ----------------------------------------------------------------
   // Host side: load, start, 72 serial clocks with select low
   // ----------------------------------------------------------------
   task automatic xfer(input logic [47:0] wr);
      int guard;
      @(negedge core_clk) bufWrData = wr;
      bufWrite = 1'b1;
      @(negedge core_clk) bufWrite = 1'b0;
      selectPinN = 1'b0;
      repeat (4) @(negedge core_clk);
      startTransferCmd = 1'b1;
      @(negedge core_clk) startTransferCmd = 1'b0;
      bufWrData = ~wr;
      bufWrite = 1'b1;
      @(negedge core_clk) bufWrite = 1'b0;
      repeat (72) begin
         repeat (4) @(negedge core_clk);
         hostSck = 1'b1;
         repeat (4) @(negedge core_clk);
         hostSck = 1'b0;
      end
      guard = 0;
      while (busy !== 1'b0 && guard < 40) begin
         @(negedge core_clk);
         guard++;
      end
      check({47'h0, busy}, 48'h0);
      selectPinN = 1'b1;
      repeat (4) @(negedge core_clk);
   endtask
   function automatic logic [47:0] pins();
      return {42'h0, gpio2Out, gpio3Out, gpio4Out, gpio2OeN, gpio3OeN, gpio4OeN};
   endfunction
   initial begin
      #200000;
      numErrors++;
      finalReport();
   end
   initial begin
      repeat (2) @(negedge core_clk);
      rst_n = 1'b1;
      repeat (4) @(negedge core_clk);
      check(bufRdData, {BUF_BYTES{BUF_RESET}});
      check(pins(), 48'h7);
      $display("test reset done");
      for (int i = 0; i < 4; i++) begin
         foreach (d[n]) d[n] = 8'($random(seed));
         slaveByte = 8'($random(seed));
         if (i == 0) begin
            d = '{8'h00, 8'hFF, 8'h80};
            slaveByte = 8'hFF;
         end
         slaveSpi = 1'b1;
         xfer({4'h8, d[0], 4'h8, 4'hA, d[1], 4'h0, 4'hA, d[2], 4'h9});
         check(bufRdData, {4'h7, d[0] & slaveByte, 4'hF, 4'h7, d[1] & slaveByte, 4'hF,
            4'h7, d[2] & slaveByte, 4'hF});
         check(pins(), 48'h7);
         slaveSpi = 1'b0;
         xfer({4'h6, d[0], 4'h0, 4'h0, d[1], 4'h9, 4'h7, d[2], 4'h0});
         check(bufRdData, {4'h6, d[0] & slaveByte, 8'h0, d[1], 4'h9, 16'h7FF0});
         check(pins(), 48'h7);
         $display("test random %0d done", i);
      end
      xfer({4'h6, d[0], 4'h8, 4'h0, d[1], 4'h8, 4'h1, d[2], 4'h0});
      check(bufRdData, {4'h6, d[0] & slaveByte, 4'hF, 4'h0, d[1], 4'hF, 4'h1, 8'hFF, 4'h0});
      check(pins(), 48'h7);
      $display("test stop and nack done");
      slaveSpi = 1'b1;
      xfer({4'hF, 8'h5A, 4'h0, 4'h9, 8'h5A, 4'h0, 4'hF, 8'h5A, 4'h0});
      check(bufRdData, {3{16'h7FFF}});
      check(pins(), 48'h7);
      $display("test no transmit done");
      finalReport();
   end
endmodule
bind gism_master gism_chk chk (.core_clk(core_clk), .rst_n(rst_n), .bufWrite(bufWrite),
   .bufWrData(bufWrData), .startTransferCmd(startTransferCmd), .hostSck(hostSck),
   .selectPinN(selectPinN), .gpio3In(gpio3In), .bufRdData(bufRdData), .busy(busy),
   .gpio2Out(gpio2Out), .gpio2OeN(gpio2OeN), .gpio3Out(gpio3Out), .gpio3OeN(gpio3OeN),
   .gpio4Out(gpio4Out), .gpio4OeN(gpio4OeN));
